// file: design/irq_prio_logic.sv
// interrupt aggregation, gating and vector sequencing with an AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module irq_prio_logic import irq_prio_pkg::*; #(
   parameter logic [7:0] PERIPH_MASK = PERIPH_MASK_DEF,
   parameter logic [QDIV_W-1:0] QTR_CLKS = QTR_CLKS_DEF
) (
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   // AHB-Lite slave
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic hreadyout_out,
   output logic hresp_out,
   output logic [31:0] hrdata_out,
   // interrupt events
   input wire logic ext_edge_evt_in,
   input wire logic port_change_evt_in,
   input wire logic timer_zero_ovf_in,
   input wire logic [7:0] periph_evt_in,
   // core sequencer side
   input wire logic return_from_irq_in,
   output logic irq_take_out,
   output logic [12:0] pc_load_addr_out,
   output logic [1:0] q_phase_out,
   output logic instr_end_out,
   // block interrupt
   output logic irq_out
);

   // one byte address decode, shared by read and write paths
   function automatic reg_sel_t decode(input logic [31:0] addr);
      reg_sel_t sel;
      sel = REG_NONE;
      unique case (addr)
         OFS_CTRL: sel = REG_CTRL;
         OFS_PFLAG: sel = REG_PFLAG;
         OFS_PEN: sel = REG_PEN;
         OFS_EVT_STS: sel = REG_EVT_STS;
         OFS_EVT_CLR: sel = REG_EVT_CLR;
         OFS_EVT_EN: sel = REG_EVT_EN;
         default: sel = REG_NONE;
      endcase
      return sel;
   endfunction : decode

   // read view of a state copy; write-only and unmapped read zero
   function automatic logic [31:0] read_mux(input reg_sel_t sel, input state_t s);
      logic [31:0] d;
      d = 32'h0000_0000;
      unique case (sel)
         REG_CTRL: d = {24'h00_0000, s.ctrl};
         REG_PFLAG: d = {24'h00_0000, s.pflag};
         REG_PEN: d = {24'h00_0000, s.pen};
         REG_EVT_STS: d = {30'h0000_0000, s.evt_sts};
         REG_EVT_EN: d = {30'h0000_0000, s.evt_en};
         REG_EVT_CLR: d = 32'h0000_0000;
         REG_NONE: d = 32'h0000_0000;
         default: d = 32'h0000_0000;
      endcase
      return d;
   endfunction : read_mux

   state_t st_reg;
   state_t st_next;
   logic qtr_end;
   logic instr_end;
   logic core_req;
   logic periph_req;
   logic req;
   logic addr_ok;
   reg_sel_t addr_sel;

   // quarter and instruction boundaries from the divider
   assign qtr_end = (st_reg.qdiv == QTR_CLKS - 8'h01);
   assign instr_end = qtr_end && (st_reg.qph == Q_LAST);

   // request gating: core sources need only their enable, peripherals the group too
   assign core_req = (st_reg.ctrl[CTRL_TMR_FLAG] && st_reg.ctrl[CTRL_TMR_EN]) ||
                     (st_reg.ctrl[CTRL_EDGE_FLAG] && st_reg.ctrl[CTRL_EDGE_EN]) ||
                     (st_reg.ctrl[CTRL_PORT_FLAG] && st_reg.ctrl[CTRL_PORT_EN]); // [RQ1] [RQ7]
   assign periph_req = st_reg.ctrl[CTRL_GROUP_EN] && |(st_reg.pflag & st_reg.pen); // [RQ8] [RQ13]
   assign req = st_reg.ctrl[CTRL_GLOBAL_EN] && (core_req || periph_req); // [RQ3] [RQ4]

   // address phase qualifier
   assign addr_ok = hsel_in && hready_in && htrans_in[1];
   assign addr_sel = decode(haddr_in);

   // next-state for the whole block
   always_comb begin
      st_next = st_reg;
      st_next.take = 1'b0;
      // divider: quarter phases advance on every qtr_end
      if (qtr_end) begin
         st_next.qdiv = '0;
         st_next.qph = st_reg.qph + 2'h1;
      end else begin
         st_next.qdiv = st_reg.qdiv + 8'h01;
      end
      // data phase write; only whole words are issued by the master
      if (st_reg.dp_wr) begin
         unique case (st_reg.dp_sel)
            REG_CTRL: st_next.ctrl = hwdata_in[7:0];
            REG_PFLAG: st_next.pflag = hwdata_in[7:0] & PERIPH_MASK; // [RQ8]
            REG_PEN: st_next.pen = hwdata_in[7:0] & PERIPH_MASK; // [RQ8]
            REG_EVT_CLR: st_next.evt_sts = st_reg.evt_sts & ~hwdata_in[EVT_W-1:0];
            REG_EVT_EN: st_next.evt_en = hwdata_in[EVT_W-1:0];
            REG_EVT_STS: st_next.evt_sts = st_reg.evt_sts;
            REG_NONE: st_next.evt_sts = st_reg.evt_sts;
            default: st_next.evt_sts = st_reg.evt_sts;
         endcase
      end
      // return instruction re-arms acceptance
      if (return_from_irq_in) begin
         st_next.ctrl[CTRL_GLOBAL_EN] = 1'b1; // [RQ6]
         st_next.evt_sts[EVT_RETURN] = 1'b1;
      end
      // hardware flag sets after the write so an event never gets lost
      if (ext_edge_evt_in) begin
         st_next.ctrl[CTRL_EDGE_FLAG] = 1'b1; // [RQ2]
      end
      if (port_change_evt_in) begin
         st_next.ctrl[CTRL_PORT_FLAG] = 1'b1; // [RQ2]
      end
      if (timer_zero_ovf_in) begin
         st_next.ctrl[CTRL_TMR_FLAG] = 1'b1; // [RQ2]
      end
      st_next.pflag = st_next.pflag | (periph_evt_in & PERIPH_MASK); // [RQ2]
      // vector sequencer steps only at instruction boundaries, so the core's
      // instruction length never enters into it; a lost request aborts
      if (instr_end) begin
         unique case (st_reg.seq)
            S_IDLE: st_next.seq = req ? S_W1 : S_IDLE; // [RQ4] [RQ12]
            S_W1: st_next.seq = req ? S_W2 : S_IDLE; // [RQ11]
            S_W2: st_next.seq = req ? S_W3 : S_IDLE; // [RQ11]
            S_W3: begin
               st_next.seq = S_IDLE;
               if (req) begin
                  st_next.take = 1'b1; // [RQ9]
                  st_next.pc_load = IRQ_VECTOR; // [RQ9]
                  st_next.ctrl[CTRL_GLOBAL_EN] = 1'b0; // [RQ9]
                  st_next.evt_sts[EVT_TAKEN] = 1'b1;
               end
            end
         endcase
      end
      // address phase capture; read data built from the updated copy so a
      // write just before the read is seen without a wait state
      st_next.dp_wr = addr_ok && hwrite_in;
      if (addr_ok) begin
         st_next.dp_sel = addr_sel;
         if (!hwrite_in) begin
            st_next.rdata = read_mux(addr_sel, st_next);
         end
      end
   end

   // single state register; reset clears the global enable
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_reg <= '{ctrl: CTRL_RESET, pflag: PERIPH_RESET, pen: PERIPH_RESET,
                     evt_sts: '0, evt_en: '0, dp_wr: 1'b0, dp_sel: REG_NONE,
                     rdata: 32'h0000_0000, qdiv: '0, qph: 2'h0, seq: S_IDLE,
                     take: 1'b0, pc_load: 13'h0000}; // [RQ5]
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs; the slave never inserts wait states and always answers okay
   assign hreadyout_out = 1'b1;
   assign hresp_out = 1'b0;
   assign hrdata_out = st_reg.rdata;
   assign irq_take_out = st_reg.take;
   assign pc_load_addr_out = st_reg.pc_load;
   assign q_phase_out = st_reg.qph;
   assign instr_end_out = instr_end;
   assign irq_out = |(st_reg.evt_sts & st_reg.evt_en);

   // bound on the vector wait in clocks: four boundaries at most
   // sized from the actual divider so the window stays tight and short
   localparam int LAT_CLKS = (LAT_INSTR + 1) * QUARTERS * int'(QTR_CLKS);

   a_edge_flag_set: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RQ2]
      ext_edge_evt_in |=> st_reg.ctrl[CTRL_EDGE_FLAG])
      else $error("edge event did not set its flag");

   a_periph_flag_set: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RQ2]
      (periph_evt_in[0] && PERIPH_MASK[0]) |=> st_reg.pflag[0])
      else $error("peripheral event did not set its flag");

   a_enable_gates_take: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RQ3]
      irq_take_out |-> $past(st_reg.ctrl[CTRL_GLOBAL_EN], 1))
      else $error("vector taken while global enable was clear");

   a_take_clears_gie: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RQ9]
      irq_take_out |-> !st_reg.ctrl[CTRL_GLOBAL_EN] && pc_load_addr_out == IRQ_VECTOR)
      else $error("service did not clear enable or load vector");

   a_return_sets_gie: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RQ6]
      return_from_irq_in |=> st_reg.ctrl[CTRL_GLOBAL_EN])
      else $error("return did not re-arm global enable");

   a_group_gates_periph: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RQ13]
      irq_take_out |-> $past(core_req) || $past(st_reg.ctrl[CTRL_GROUP_EN]))
      else $error("peripheral request passed with group enable clear");

   a_take_on_boundary: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RQ12]
      irq_take_out |-> $past(instr_end) && $past(st_reg.seq) == S_W3)
      else $error("vector not aligned to an instruction boundary");

   a_take_latency: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RQ11]
      (instr_end && st_reg.seq == S_IDLE && req) |-> ##[1:LAT_CLKS] (irq_take_out || !req))
      else $error("pending request was not vectored in time");

   a_no_early_take: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RQ11]
      (instr_end && st_reg.seq == S_IDLE && req) |=> !irq_take_out)
      else $error("vector taken before the minimum latency");

   a_taken_status: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
      irq_take_out |-> st_reg.evt_sts[EVT_TAKEN])
      else $error("taken event not recorded in status");

   // remaining flag sources, each sets regardless of any enable
   a_port_flag_set: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RQ2]
      port_change_evt_in |=> st_reg.ctrl[CTRL_PORT_FLAG])
      else $error("port change event did not set its flag");

   a_timer_flag_set: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RQ2]
      timer_zero_ovf_in |=> st_reg.ctrl[CTRL_TMR_FLAG])
      else $error("timer overflow did not set its flag");

   // one check per implemented peripheral line
   for (genvar i = 0; i < 8; i++) begin : g_periph_chk
      if (PERIPH_MASK[i]) begin : g_impl
         a_periph_bit_set: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RQ2]
            periph_evt_in[i] |=> st_reg.pflag[i])
            else $error("peripheral event bit did not set its flag");
      end
   end

   // flags are sticky: only a software write takes them down
   a_edge_flag_sticky: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RQ2]
      (st_reg.ctrl[CTRL_EDGE_FLAG] && !(st_reg.dp_wr && st_reg.dp_sel == REG_CTRL))
      |=> st_reg.ctrl[CTRL_EDGE_FLAG])
      else $error("edge flag dropped without a write");

   a_pflag_sticky: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RQ2]
      (st_reg.pflag[0] && !(st_reg.dp_wr && st_reg.dp_sel == REG_PFLAG)) |=> st_reg.pflag[0])
      else $error("peripheral flag dropped without a write");

   a_unimpl_bits_zero: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RQ1]
      (st_reg.pflag & ~PERIPH_MASK) == 8'h00 && (st_reg.pen & ~PERIPH_MASK) == 8'h00)
      else $error("unimplemented peripheral bit became set");

   // reset checks run without a disable so they see the reset itself
   a_reset_clears_enable: assert property (@(posedge clk_sys_in) // [RQ5]
      !arst_n_in |-> !st_reg.ctrl[CTRL_GLOBAL_EN])
      else $error("global enable set during reset");

   a_reset_no_take: assert property (@(posedge clk_sys_in) // [RQ5]
      !arst_n_in |-> !irq_take_out && st_reg.seq == S_IDLE)
      else $error("sequencer active during reset");

   // sequencer stepping, one state per instruction boundary
   a_disabled_no_start: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RQ3]
      (instr_end && !st_reg.ctrl[CTRL_GLOBAL_EN]) |=> st_reg.seq == S_IDLE && !irq_take_out)
      else $error("sequencer ran with global enable clear");

   a_start_on_request: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RQ4]
      (instr_end && st_reg.seq == S_IDLE && req) |=> st_reg.seq == S_W1)
      else $error("enabled request did not start the sequencer");

   a_wait_steps: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RQ11]
      (instr_end && st_reg.seq == S_W1 && req) |=> st_reg.seq == S_W2)
      else $error("sequencer did not leave first wait");

   a_wait_last: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RQ11]
      (instr_end && st_reg.seq == S_W2 && req) |=> st_reg.seq == S_W3)
      else $error("sequencer did not reach last wait");

   a_lost_req_aborts: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RQ4]
      (instr_end && !req) |=> st_reg.seq == S_IDLE && !irq_take_out)
      else $error("vanished request was not aborted");

   a_seq_off_boundary: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RQ12]
      !instr_end |=> $stable(st_reg.seq))
      else $error("sequencer moved between boundaries");

   a_group_blocks_start: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RQ13]
      (instr_end && st_reg.seq == S_IDLE && !st_reg.ctrl[CTRL_GROUP_EN] && !core_req)
      |=> st_reg.seq == S_IDLE)
      else $error("peripheral request started with group enable clear");

   a_core_no_group: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RQ7]
      (instr_end && st_reg.seq == S_IDLE && st_reg.ctrl[CTRL_GLOBAL_EN] && core_req)
      |=> st_reg.seq == S_W1)
      else $error("core source held back by group enable");

   // vector handover
   a_take_one_cycle: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RQ9]
      irq_take_out |=> !irq_take_out)
      else $error("take pulse longer than one cycle");

   a_vector_held: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RQ9]
      irq_take_out |=> pc_load_addr_out == IRQ_VECTOR)
      else $error("vector address not held after take");

   a_return_status: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
      return_from_irq_in |=> st_reg.evt_sts[EVT_RETURN])
      else $error("return not recorded in status");

   // divider and phase counter
   a_qph_advance: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RQ11]
      qtr_end |=> st_reg.qph == $past(st_reg.qph) + 2'h1)
      else $error("quarter phase did not advance");

   a_qdiv_bounded: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
      st_reg.qdiv < QTR_CLKS)
      else $error("divider ran past its terminal count");

   // register slave behaviour
   a_read_data_stable: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
      !(addr_ok && !hwrite_in) |=> $stable(hrdata_out))
      else $error("read data changed without a read");

   a_group_write: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RQ8]
      (st_reg.dp_wr && st_reg.dp_sel == REG_CTRL)
      |=> st_reg.ctrl[CTRL_GROUP_EN] == $past(hwdata_in[CTRL_GROUP_EN]))
      else $error("group enable write did not land");

   a_pen_write: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RQ8]
      (st_reg.dp_wr && st_reg.dp_sel == REG_PEN)
      |=> st_reg.pen == ($past(hwdata_in[7:0]) & PERIPH_MASK))
      else $error("peripheral enable write did not land");

   a_clear_event: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
      (st_reg.dp_wr && st_reg.dp_sel == REG_EVT_CLR && hwdata_in[EVT_TAKEN] &&
       !(instr_end && st_reg.seq == S_W3 && req)) |=> !st_reg.evt_sts[EVT_TAKEN])
      else $error("event clear did not clear taken status");

endmodule : irq_prio_logic
`default_nettype wire

// file: design/irq_prio_pkg.sv
// constants, types and state layout for the interrupt aggregation block
// Function
// [RQ1] nine sources, each with flag and enable
// [RQ2] flags set regardless of any enable
// [RQ3] global enable bit 7 gates every interrupt
// [RQ4] enabled pending flag vectors with no extra condition
// [RQ5] every reset clears the global enable
// [RQ6] return instruction sets global enable again
// [RQ7] edge, port, timer flags and enables in control
// [RQ8] peripheral flags, enables separate; group enable in control
// [RQ9] service clears global enable, pushes, loads 0004h
// [RQ10] software polls and clears flags before re-enabling
// [RQ11] external event latency three or four instruction cycles
// [RQ12] latency independent of instruction length
// [RQ13] peripheral request also needs group enable
package irq_prio_pkg;
   // control register bit positions
   localparam int CTRL_GLOBAL_EN = 7;
   localparam int CTRL_GROUP_EN = 6;
   localparam int CTRL_TMR_EN = 5;
   localparam int CTRL_EDGE_EN = 4;
   localparam int CTRL_PORT_EN = 3;
   localparam int CTRL_TMR_FLAG = 2;
   localparam int CTRL_EDGE_FLAG = 1;
   localparam int CTRL_PORT_FLAG = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] PERIPH_RESET = 8'h00;
   // implemented peripheral bits: six sources, three more live in control
   localparam logic [7:0] PERIPH_MASK_DEF = 8'h5F;
   // interrupt vector loaded into the program counter
   localparam logic [12:0] IRQ_VECTOR = 13'h0004;
   // byte offsets on the bus
   localparam logic [31:0] OFS_CTRL = 32'h0000_0000;
   localparam logic [31:0] OFS_PFLAG = 32'h0000_0004;
   localparam logic [31:0] OFS_PEN = 32'h0000_0008;
   localparam logic [31:0] OFS_EVT_STS = 32'h0000_000C;
   localparam logic [31:0] OFS_EVT_CLR = 32'h0000_0010;
   localparam logic [31:0] OFS_EVT_EN = 32'h0000_0014;
   // event status bits
   localparam int EVT_TAKEN = 0;
   localparam int EVT_RETURN = 1;
   localparam int EVT_W = 2;
   // quarter-cycle divider
   localparam int QDIV_W = 8;
   localparam logic [QDIV_W-1:0] QTR_CLKS_DEF = 8'h01;
   localparam logic [1:0] Q_LAST = 2'h3;
   localparam int QUARTERS = 4;
   // waits at instruction boundaries before the vector
   localparam int LAT_INSTR = 3;

   typedef enum logic [2:0] {
      REG_CTRL = 3'b000,
      REG_PFLAG = 3'b001,
      REG_PEN = 3'b010,
      REG_EVT_STS = 3'b011,
      REG_EVT_CLR = 3'b100,
      REG_EVT_EN = 3'b101,
      REG_NONE = 3'b111
   } reg_sel_t;

   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_W1 = 2'b01,
      S_W2 = 2'b10,
      S_W3 = 2'b11
   } seq_t;

   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] pflag;
      logic [7:0] pen;
      logic [EVT_W-1:0] evt_sts;
      logic [EVT_W-1:0] evt_en;
      logic dp_wr;
      reg_sel_t dp_sel;
      logic [31:0] rdata;
      logic [QDIV_W-1:0] qdiv;
      logic [1:0] qph;
      seq_t seq;
      logic take;
      logic [12:0] pc_load;
   } state_t;
endpackage : irq_prio_pkg

// file: sim/core_seq_model.sv
// core sequencer model: takes the vector and issues the return pulse
`timescale 1ns/1ps
`default_nettype none
module core_seq_model (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic take_in,
   input wire logic [12:0] pc_in,
   input wire logic ret_go_in,
   output logic ret_out,
   output int takes_out,
   output logic [12:0] vec_out
);
   logic in_isr_reg;
   // a return outside a routine is dropped, so only real returns re-arm
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         in_isr_reg <= 1'b0;
         ret_out <= 1'b0;
         takes_out <= 0;
         vec_out <= 13'h0000;
      end else begin
         ret_out <= ret_go_in & in_isr_reg;
         if (take_in) begin
            // push and jump to the vector
            in_isr_reg <= 1'b1;
            takes_out <= takes_out + 1;
            vec_out <= pc_in;
         end else if (ret_go_in) begin
            in_isr_reg <= 1'b0;
         end
      end
   end
endmodule : core_seq_model
`default_nettype wire

// file: sim/test_mcu_interrupt_priority_logic.sv
// self-checking bench for the interrupt aggregation block
`timescale 1ns/1ps
`default_nettype none
module test_mcu_interrupt_priority_logic import irq_prio_pkg::*;;
   logic clk=0, arst_n=0, hsel=0, hwrite=0, ext=0, prt=0, tmr=0, ret_go=0, ret, hready, take, irq;
   logic [1:0] htrans=2'h0, qph;
   logic [2:0] hsize=3'h2;
   logic [31:0] haddr=32'h0, hwdata=32'h0, hrdata, rd;
   logic [7:0] per=8'h00;
   logic [12:0] pc, vec;
   logic hresp, iend;
   int mismatches=0, cmp_count=0, cycles=0, takes;

   always #5 clk = ~clk;

   irq_prio_logic DUT (.clk_sys_in(clk), .arst_n_in(arst_n), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
      .hready_in(hready), .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata),
      .ext_edge_evt_in(ext), .port_change_evt_in(prt), .timer_zero_ovf_in(tmr),
      .periph_evt_in(per), .return_from_irq_in(ret), .irq_take_out(take),
      .pc_load_addr_out(pc), .q_phase_out(qph), .instr_end_out(iend), .irq_out(irq));

   core_seq_model core (.clk_in(clk), .arst_n_in(arst_n), .take_in(take), .pc_in(pc),
      .ret_go_in(ret_go), .ret_out(ret), .takes_out(takes), .vec_out(vec));

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : report_and_stop

   // hang guard, far above the few hundred cycles the run needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         report_and_stop();
      end
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         $display("unexpected %s expected %h seen %h", nm, e, s);
         mismatches++;
      end
   endtask : chk

   // one single AHB transfer; held until hready is sampled high each phase
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
      chk("bus response", 32'h0, {31'h0, hresp});
   endtask : bus

   // cycles until a take, sampled after each edge settles
   task automatic wait_take(output int n);
      n = 0;
      while (take !== 1'b1 && n < 60) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask : wait_take

   task automatic pulse(input logic [10:0] v);
      @(posedge clk);
      {ext, prt, tmr, per} <= v;
      @(posedge clk);
      {ext, prt, tmr, per} <= 11'h000;
   endtask : pulse

   task automatic t_reset;
      bus(1'b1, OFS_CTRL, 32'h80);
      @(posedge clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      bus(1'b0, OFS_CTRL, 32'h0);
      chk("ctrl after reset", 32'h0, rd);
      bus(1'b0, 32'h0000_0040, 32'h0);
      chk("unmapped read", 32'h0, rd);
      // boundary pulse must fall in the last quarter
      while (iend !== 1'b1) @(posedge clk);
      chk("phase at boundary", {30'h0, Q_LAST}, {30'h0, qph});
   endtask : t_reset

   task automatic t_flags;
      int n;
      pulse(11'h7FF);
      wait_take(n);
      chk("take while disabled", 32'd60, n);
      bus(1'b0, OFS_CTRL, 32'h0);
      chk("ctrl flags", 32'h07, rd);
      bus(1'b0, OFS_PFLAG, 32'h0);
      chk("periph flags", {24'h0, PERIPH_MASK_DEF}, rd);
      bus(1'b1, OFS_CTRL, 32'h0);
      bus(1'b1, OFS_PFLAG, 32'h0);
   endtask : t_flags

   task automatic t_take;
      int n;
      bus(1'b1, OFS_EVT_EN, 32'h3);
      bus(1'b1, OFS_CTRL, 32'h90);
      pulse(11'h400);
      wait_take(n);
      chk("latency in range", 32'h1, {31'h0, n >= 12 && n <= 19});
      repeat (2) @(posedge clk);
      chk("vector", {19'h0, IRQ_VECTOR}, {19'h0, vec});
      chk("irq level", 32'h1, {31'h0, irq});
      bus(1'b0, OFS_CTRL, 32'h0);
      chk("ctrl after take", 32'h12, rd);
      bus(1'b1, OFS_EVT_CLR, 32'h1);
      @(posedge clk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      bus(1'b1, OFS_CTRL, 32'h10);
      ret_go <= 1'b1;
      @(posedge clk);
      ret_go <= 1'b0;
      repeat (2) @(posedge clk);
      bus(1'b0, OFS_CTRL, 32'h0);
      chk("ctrl after return", 32'h90, rd);
      bus(1'b0, OFS_EVT_STS, 32'h0);
      chk("return status", 32'h2, rd);
      bus(1'b1, OFS_EVT_CLR, 32'h3);
   endtask : t_take

   task automatic t_periph;
      int n;
      bus(1'b1, OFS_PEN, 32'h1);
      bus(1'b1, OFS_PFLAG, 32'h1);
      bus(1'b1, OFS_CTRL, 32'h80);
      wait_take(n);
      chk("take without group", 32'd60, n);
      bus(1'b1, OFS_CTRL, 32'hC0);
      wait_take(n);
      chk("take with group", 32'h1, {31'h0, n < 25});
      repeat (2) @(posedge clk);
      chk("take count", 32'd2, takes);
   endtask : t_periph

   initial begin
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      t_reset();
      t_flags();
      t_take();
      t_periph();
      report_and_stop();
   end
endmodule : test_mcu_interrupt_priority_logic
`default_nettype wire
